// *** scd_pkg.sv ***
// Purpose: Shared constants and types for the sample clock divider block
// Assumes: CLK_IN at 100 MHz; register access through the three-wire serial port
// Notes: Offsets are 13-bit serial port addresses

package scd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int DCS_LOCK_NS = 1500;
    localparam int DCS_LOCK_CYC = (DCS_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PERIOD_W = 8;
    localparam logic [PERIOD_W-1:0] PERIOD_SAT = 8'hff;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [12:0] ADDR_DIV_RATIO = 13'h008;
    localparam logic [12:0] ADDR_CLK_SRC = 13'h009;
    localparam logic [12:0] ADDR_DCS_CTRL = 13'h00b;
    localparam logic [12:0] ADDR_CLK_STATUS = 13'h00c;
    localparam logic [12:0] ADDR_SYNC_CTRL = 13'h03a;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam int SRC_RF_BIT = 0;
    localparam int DCS_EN_BIT = 0;
    localparam int SYNC_EN_BIT = 1;
    localparam int SYNC_EVERY_BIT = 2;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_RF_BIT = 2;
    localparam int STAT_ARMED_BIT = 3;
    localparam logic [7:0] DIV_RATIO_RST = 8'h00;
    localparam logic [7:0] CLK_SRC_RST = 8'h00;
    localparam logic [7:0] DCS_CTRL_RST = 8'h01;
    localparam logic [7:0] SYNC_CTRL_RST = 8'h00;

    // ************************************************************
    // Predivider and serial frame
    // ************************************************************
    localparam int RF_PREDIV = 4;
    localparam logic [1:0] PREDIV_RISE = 2'h1;
    localparam logic [4:0] SPI_HDR_LAST = 5'h0f;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;

    typedef enum logic [4:0] {
        SPI_IDLE = 5'b00001,
        SPI_HDR = 5'b00010,
        SPI_WR = 5'b00100,
        SPI_RD = 5'b01000,
        SPI_END = 5'b10000
    } scd_spi_state_t;

endpackage : scd_pkg

// *** scd_sync.sv ***
// Purpose: Two-flop synchroniser with a third stage for edge detection
// Assumes: Inputs are asynchronous to CLK_IN
// Notes: Stage one feeds stage two only

module scd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,                // System clock
    input wire logic srst_in,               // Synchronous reset
    input wire logic [WIDTH-1:0] d_in,      // Asynchronous inputs
    output logic [WIDTH-1:0] q_out,         // Synchronised level
    output logic [WIDTH-1:0] q_dly_out      // Level one cycle older
);

    logic [WIDTH-1:0] meta_reg;

    // ************************************************************
    // Three stages
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_reg <= '0;
            q_out <= '0;
            q_dly_out <= '0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
            q_dly_out <= q_out;
        end
    end

endmodule : scd_sync

// *** scd_clock_divider.sv ***
// Purpose: Sample clock source select, predivider, integer divider, sync and DUTY_CYCLE_STABILISER
// Assumes: Clock pins and serial pins are slow enough to be sampled at 100 MHz
// Notes: Input clocks are sampled; edges are seen up to three cycles late

module scd_clock_divider import scd_pkg::*; (
    input wire logic CLK_IN,                // System clock, 100 MHz
    input wire logic SRST_IN,               // Synchronous reset, active high
    input wire logic NYQ_CLK_IN,            // Nyquist sample clock input
    input wire logic HIGH_FREQ_CLOCK_IN,    // RF clock input
    input wire logic SYSREF_IN,             // External sync pulse
    input wire logic SPI_SCLK_IN,           // Serial port clock
    input wire logic SPI_CSB_N_IN,          // Serial port select, active low
    input wire logic SPI_SDIO_IN,           // Serial data pin, input side
    output logic SPI_SDIO_OUT,              // Serial data pin, output side
    output logic SPI_SDIO_OE_N_OUT,         // Serial data drive enable, active low
    output logic SAMPLE_CLK_OUT,            // Internal sampling clock
    output logic SAMPLE_STROBE_OUT,         // Pulse on each sampling edge
    output logic DCS_LOCKED_OUT,            // Stabiliser loop locked
    output logic DCS_ACTIVE_OUT             // Stabiliser enabled
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Select enters inverted so the reset level of the flops means idle
    logic [5:0] pin_q, pin_qd;
    wire cs_pin = ~SPI_CSB_N_IN;
    scd_sync #(.WIDTH(6)) u_sync (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .d_in({SYSREF_IN, HIGH_FREQ_CLOCK_IN, NYQ_CLK_IN, SPI_SDIO_IN, cs_pin, SPI_SCLK_IN}),
        .q_out(pin_q),
        .q_dly_out(pin_qd)
    );
    wire sclk_rise = pin_q[0] & ~pin_qd[0];
    wire cs_active = pin_q[1];
    wire sdio_q = pin_q[2];
    wire nyq_level = pin_q[3];
    wire nyq_edge = pin_q[3] & ~pin_qd[3];
    wire rf_edge = pin_q[4] & ~pin_qd[4];
    wire sysref_edge = pin_q[5] & ~pin_qd[5];

    // ************************************************************
    // Serial port
    // ************************************************************
    scd_spi_state_t spi_state_reg, spi_state_next;
    logic [4:0] bit_cnt_reg;
    logic [15:0] shift_reg;
    logic [12:0] addr_reg;
    logic [7:0] rd_shift_reg;
    logic [7:0] ratio_reg, src_reg, dcs_reg, sync_reg;
    logic armed_reg, locked_reg;
    logic [RATIO_W-1:0] act_m1_reg;
    logic act_rf_reg;

    // Header fields and write strobe
    wire [12:0] hdr_addr = {shift_reg[11:0], sdio_q};
    wire hdr_read = shift_reg[14];
    wire hdr_done = (spi_state_reg == SPI_HDR) && sclk_rise && (bit_cnt_reg == SPI_HDR_LAST);
    wire wr_fire = (spi_state_reg == SPI_WR) && sclk_rise && (bit_cnt_reg == SPI_FRAME_LAST);
    wire [7:0] wdata = {shift_reg[6:0], sdio_q};
    wire dcs_active = dcs_reg[DCS_EN_BIT] | (ratio_reg[RATIO_LSB +: RATIO_W] != '0);
    wire [7:0] status = {4'h0, armed_reg, act_rf_reg, dcs_active, locked_reg};

    // Read data mux, unmapped addresses read zero
    wire [7:0] rd_data = (hdr_addr == ADDR_DIV_RATIO) ? ratio_reg :
                         (hdr_addr == ADDR_CLK_SRC) ? src_reg :
                         (hdr_addr == ADDR_DCS_CTRL) ? dcs_reg :
                         (hdr_addr == ADDR_CLK_STATUS) ? status :
                         (hdr_addr == ADDR_SYNC_CTRL) ? sync_reg : 8'h00;

    // Frame sequencing
    always_comb begin
        spi_state_next = spi_state_reg;
        case (spi_state_reg)
            SPI_IDLE: if (cs_active) spi_state_next = SPI_HDR;
            SPI_HDR: if (hdr_done) spi_state_next = hdr_read ? SPI_RD : SPI_WR;
            SPI_WR: if (wr_fire) spi_state_next = SPI_END;
            SPI_RD: if (sclk_rise && bit_cnt_reg == SPI_FRAME_LAST) spi_state_next = SPI_END;
            SPI_END: spi_state_next = SPI_END;
            default: spi_state_next = SPI_IDLE;
        endcase
        if (!cs_active) begin
            spi_state_next = SPI_IDLE;
        end
    end

    // Serial shifting
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || !cs_active) begin
            bit_cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            shift_reg <= {shift_reg[14:0], sdio_q};
        end
    end

    // State, address and read shifter
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            spi_state_reg <= SPI_IDLE;
            addr_reg <= 13'h0000;
            rd_shift_reg <= 8'h00;
        end else begin
            spi_state_reg <= spi_state_next;
            if (hdr_done) begin
                addr_reg <= hdr_addr;
                rd_shift_reg <= rd_data;
            end else if (spi_state_reg == SPI_RD && sclk_rise) begin
                rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            end
        end
    end
    assign SPI_SDIO_OUT = rd_shift_reg[7];
    assign SPI_SDIO_OE_N_OUT = !((spi_state_reg == SPI_RD) && cs_active);

    // Register writes
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ratio_reg <= DIV_RATIO_RST;
            src_reg <= CLK_SRC_RST;
            dcs_reg <= DCS_CTRL_RST;
            sync_reg <= SYNC_CTRL_RST;
        end else if (wr_fire) begin
            if (addr_reg == ADDR_DIV_RATIO) ratio_reg <= wdata;
            if (addr_reg == ADDR_CLK_SRC) src_reg <= wdata;
            if (addr_reg == ADDR_DCS_CTRL) dcs_reg <= wdata;
            if (addr_reg == ADDR_SYNC_CTRL) sync_reg <= wdata;
        end
    end

    // ************************************************************
    // Source select, predivider and divider
    // ************************************************************
    logic [1:0] prediv_reg;
    logic [RATIO_W-1:0] div_cnt_reg;
    wire sync_wr = wr_fire && (addr_reg == ADDR_SYNC_CTRL);
    wire sync_fire = sysref_edge && sync_reg[SYNC_EN_BIT] &&
                     (sync_reg[SYNC_EVERY_BIT] || armed_reg);
    wire src_edge = act_rf_reg ? (rf_edge && prediv_reg == PREDIV_RISE) : nyq_edge;
    wire src_level = act_rf_reg ? prediv_reg[1] : nyq_level;
    wire div_wrap = src_edge && (div_cnt_reg == act_m1_reg);
    wire apply = sync_fire || div_wrap;
    wire rise = src_edge && (div_cnt_reg == '0) && !sync_fire;

    // Divider counters, settings latched at boundaries
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            prediv_reg <= 2'h0;
            div_cnt_reg <= '0;
            act_m1_reg <= '0;
            act_rf_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            prediv_reg <= sync_fire ? 2'h0 : prediv_reg + 2'(rf_edge);
            if (sync_fire || div_wrap) div_cnt_reg <= '0;
            else if (src_edge) div_cnt_reg <= div_cnt_reg + 1'b1;
            if (apply) begin
                act_m1_reg <= ratio_reg[RATIO_LSB +: RATIO_W];
                act_rf_reg <= src_reg[SRC_RF_BIT];
            end
            armed_reg <= sync_wr ? 1'b1 : (sync_fire ? 1'b0 : armed_reg);
        end
    end

    // ************************************************************
    // Duty cycle stabiliser
    // ************************************************************
    logic [PERIOD_W-1:0] per_cnt_reg, last_per_reg, high_cnt_reg, lock_cnt_reg, lock_cnt_next;
    wire per_sat = (per_cnt_reg == PERIOD_SAT);
    wire per_match = (per_cnt_reg == last_per_reg) || (per_cnt_reg == last_per_reg + 1'b1) ||
                     (last_per_reg == per_cnt_reg + 1'b1);
    wire [PERIOD_W-1:0] half = last_per_reg >> 1;
    wire dcs_use = dcs_active && locked_reg;
    wire clk_next = sync_fire ? 1'b0 : rise ? 1'b1 :
                    dcs_use ? (high_cnt_reg >= half ? 1'b0 : SAMPLE_CLK_OUT) :
                    (src_level ? SAMPLE_CLK_OUT : 1'b0);

    // Lock counting restarts when the period changes by more than one cycle
    always_comb begin
        lock_cnt_next = lock_cnt_reg;
        if (!dcs_active || per_sat || (rise && !per_match)) begin
            lock_cnt_next = '0;
        end else if (lock_cnt_reg != PERIOD_W'(DCS_LOCK_CYC)) begin
            lock_cnt_next = lock_cnt_reg + 1'b1;
        end
    end

    // Period measure, high time and output clock
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            per_cnt_reg <= '0;
            last_per_reg <= '0;
            high_cnt_reg <= '0;
            lock_cnt_reg <= '0;
            locked_reg <= 1'b0;
            SAMPLE_CLK_OUT <= 1'b0;
            SAMPLE_STROBE_OUT <= 1'b0;
            DCS_ACTIVE_OUT <= 1'b0;
        end else begin
            per_cnt_reg <= rise ? PERIOD_W'(1) : (per_sat ? per_cnt_reg : per_cnt_reg + 1'b1);
            if (rise) last_per_reg <= per_cnt_reg;
            high_cnt_reg <= rise ? PERIOD_W'(1) : (per_sat ? high_cnt_reg : high_cnt_reg + 1'b1);
            lock_cnt_reg <= lock_cnt_next;
            locked_reg <= (lock_cnt_next == PERIOD_W'(DCS_LOCK_CYC));
            SAMPLE_CLK_OUT <= clk_next;
            SAMPLE_STROBE_OUT <= rise;
            DCS_ACTIVE_OUT <= dcs_active;
        end
    end
    assign DCS_LOCKED_OUT = locked_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    src_reset_a: assert property ($past(SRST_IN) |-> !src_reg[SRC_RF_BIT] && !act_rf_reg)
        else $error("source not Nyquist after reset");
    prediv_a: assert property (act_rf_reg && src_edge && !sync_fire |=> prediv_reg == 2'h2)
        else $error("RF predivider edge misplaced");
    div_wrap_a: assert property (src_edge && !div_wrap && !sync_fire |=> div_cnt_reg == $past(div_cnt_reg) + 1'b1)
        else $error("divider count did not advance");
    dcs_auto_a: assert property (ratio_reg[RATIO_LSB +: RATIO_W] != '0 |=> DCS_ACTIVE_OUT)
        else $error("stabiliser not forced on");
    sync_once_a: assert property (sync_fire && !sync_reg[SYNC_EVERY_BIT] && !sync_wr |=> !armed_reg)
        else $error("one-shot sync stayed armed");
    sync_reset_a: assert property (sync_fire |=> div_cnt_reg == '0 && !SAMPLE_CLK_OUT && prediv_reg == 2'h0)
        else $error("sync did not reset divider");
    dcs_fall_a: assert property (dcs_use && !rise && !sync_fire && high_cnt_reg >= half |=> !SAMPLE_CLK_OUT)
        else $error("stabiliser falling edge late");
    lock_time_a: assert property ($rose(locked_reg) |-> lock_cnt_reg == PERIOD_W'(DCS_LOCK_CYC))
        else $error("lock before wait time");
    bypass_a: assert property (!dcs_use && !rise && !sync_fire && !src_level |=> !SAMPLE_CLK_OUT)
        else $error("bypass did not follow input");
    strobe_a: assert property (SAMPLE_STROBE_OUT |-> SAMPLE_CLK_OUT && !$past(SAMPLE_CLK_OUT))
        else $error("strobe not on rising edge");
    no_runt_a: assert property ($changed(act_m1_reg) || $changed(act_rf_reg) |-> $past(apply))
        else $error("settings changed mid period");

    one_shot_c: cover property (sync_fire && !sync_reg[SYNC_EVERY_BIT]);
    lock_c: cover property ($rose(locked_reg));
    rf_rise_c: cover property (act_rf_reg && rise);
    spi_wr_c: cover property (wr_fire);

endmodule : scd_clock_divider

// *** scd_clk_src_model.sv ***
// Purpose: Far-side clock source and sync pulse generator for the divider
// Assumes: Runs on the bench system clock; outputs change on its rising edge
// Notes: RF clock has a fixed four-cycle period, the Nyquist phases are set

// ************************************************************
// Clock source model
// ************************************************************
module scd_clk_src_model (
    input wire logic clk_in,            // System clock
    input wire logic [7:0] hi_in,       // Nyquist high phase, cycles
    input wire logic [7:0] lo_in,       // Nyquist low phase, cycles
    input wire logic sync_req_in,       // Request one sync pulse
    output logic nyq_clk_out,           // Nyquist clock
    output logic rf_clk_out,            // RF clock
    output logic sysref_out             // Sync pulse, four cycles wide
);
    logic [7:0] cnt;
    logic rf_ph;
    logic [2:0] sys_cnt;

    // Known levels at time zero
    initial begin
        nyq_clk_out = 1'b0;
        rf_clk_out = 1'b0;
        sysref_out = 1'b0;
        cnt = 8'h00;
        rf_ph = 1'b0;
        sys_cnt = 3'h0;
    end

    // Free-running sources, phases kept well under the slow limit
    always @(posedge clk_in) begin
        if (nyq_clk_out ? (cnt >= hi_in - 8'h01) : (cnt >= lo_in - 8'h01)) begin
            nyq_clk_out <= ~nyq_clk_out;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
        rf_ph <= ~rf_ph;
        if (rf_ph) begin
            rf_clk_out <= ~rf_clk_out;
        end
        sys_cnt <= sync_req_in ? 3'h4 : (sys_cnt != 3'h0 ? sys_cnt - 3'h1 : 3'h0);
        sysref_out <= (sys_cnt != 3'h0);
    end
endmodule : scd_clk_src_model

// *** scd_clock_divider_tb.sv ***
// Purpose: Self-checking bench for the sample clock divider
// Assumes: Serial frames of 24 bits, SCLK phases of five cycles
// Notes: Gaps and phase lengths are counted in system clock cycles

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module scd_clock_divider_tb import scd_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, sclk, csb, sdio_drv, req, sdo, oe_n, sclk_o, strobe, locked, active;
    logic nyq, rf, sysref, prev_clk, runt_on;
    logic [7:0] hi, lo, q, v;
    wire logic sdio_w;
    int n_errors, compares, seed, i, n, m, run;
    logic [12:0] rst_a [5] = '{ADDR_DIV_RATIO, ADDR_CLK_SRC, ADDR_DCS_CTRL, ADDR_SYNC_CTRL, 13'h100};
    logic [7:0] rst_v [5] = '{DIV_RATIO_RST, CLK_SRC_RST, DCS_CTRL_RST, SYNC_CTRL_RST, 8'h00};
    logic [7:0] sync_m [3] = '{8'h06, 8'h02, 8'h00};
    logic [1:0] sync_e [3] = '{2'b11, 2'b10, 2'b00};

    // ************************************************************
    // Clock, pin resolution and instances
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    assign sdio_w = oe_n ? sdio_drv : sdo;

    scd_clock_divider scd_clock_divider_i (.CLK_IN(clk), .SRST_IN(srst), .NYQ_CLK_IN(nyq),
        .HIGH_FREQ_CLOCK_IN(rf), .SYSREF_IN(sysref), .SPI_SCLK_IN(sclk), .SPI_CSB_N_IN(csb),
        .SPI_SDIO_IN(sdio_w), .SPI_SDIO_OUT(sdo), .SPI_SDIO_OE_N_OUT(oe_n),
        .SAMPLE_CLK_OUT(sclk_o), .SAMPLE_STROBE_OUT(strobe), .DCS_LOCKED_OUT(locked),
        .DCS_ACTIVE_OUT(active));
    scd_clk_src_model scd_clk_src_model_i (.clk_in(clk), .hi_in(hi), .lo_in(lo),
        .sync_req_in(req), .nyq_clk_out(nyq), .rf_clk_out(rf), .sysref_out(sysref));

    // ************************************************************
    // Tasks and functions
    // ************************************************************
    task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                       output logic [7:0] qo);
        logic [23:0] f;
        int k;
        f = {rd, 2'b00, a, wd};
        qo = 8'h00;
        @(posedge clk);
        #1 csb = 1'b0;
        for (k = 0; k < 24; k++) begin
            sdio_drv = f[23-k];
            repeat (5) @(posedge clk);
            #1 if (k >= 16) qo[23-k] = sdio_w;
            sclk = 1'b1;
            repeat (5) @(posedge clk);
            #1 sclk = 1'b0;
        end
        repeat (5) @(posedge clk);
        #1 csb = 1'b1;
        repeat (5) @(posedge clk);
    endtask : spi

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi(1'b0, a, d, x);
    endtask : wr

    task automatic next_strobe(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (strobe !== 1'b1 && c < 4000);
        if (c >= 4000) begin
            n_errors++;
            $display("Error at %0t: no sampling edge", $time);
        end
    endtask : next_strobe

    task automatic gap(output int g);
        int d;
        next_strobe(d);
        next_strobe(d);
        next_strobe(g);
    endtask : gap

    task automatic hi_time(output int h);
        int d;
        next_strobe(d);
        h = 0;
        while (sclk_o === 1'b1 && h < 400) begin
            @(posedge clk);
            #1 h++;
        end
    endtask : hi_time

    task automatic sync_probe(output int c);
        int d;
        next_strobe(d);
        repeat (15 + ($random(seed) & 7)) @(posedge clk);
        #1 req = 1'b1;
        @(posedge clk);
        #1 req = 1'b0;
        next_strobe(c);
    endtask : sync_probe

    function automatic int exp_gap(input logic rf_p, input logic [2:0] r);
        return (rf_p ? 4 * 4 : int'(hi) + int'(lo)) * (int'(r) + 1);
    endfunction : exp_gap

    task complete_run;
        $display("Compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // ************************************************************
    // Monitors and watchdog
    // ************************************************************
    // Strobe marks a rising edge; no runt phases after reconfiguration
    always @(posedge clk) begin
        #1;
        if (!srst) begin
            if (strobe === 1'b1) `CHK({prev_clk, sclk_o}, 2'b01)
            if (sclk_o !== prev_clk) begin
                if (runt_on) `CHK(run >= 2, 1'b1)
                run = 1;
            end else begin
                run++;
            end
        end
        prev_clk = sclk_o;
    end

    // Hang guard
    initial begin
        #300000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 8;
        n_errors = 0;
        compares = 0;
        srst = 1'b1;
        sclk = 1'b0;
        csb = 1'b1;
        sdio_drv = 1'b0;
        req = 1'b0;
        hi = 8'h05;
        lo = 8'h05;
        runt_on = 1'b0;
        prev_clk = 1'b0;
        run = 0;
        repeat (16) @(posedge clk);
        #1;
        `CHK({sclk_o, strobe, locked, active, oe_n}, 5'b00001)
        srst = 1'b0;
        for (i = 0; i < 5; i++) begin
            spi(1'b1, rst_a[i], 8'h00, q);
            `CHK(q, rst_v[i])
        end
        runt_on = 1'b1;
        for (i = 0; i < 8; i++) begin
            wr(ADDR_DIV_RATIO, 8'(i));
            gap(n);
            `CHK(n, exp_gap(1'b0, 3'(i)))
        end
        v = 8'($random(seed));
        wr(ADDR_CLK_SRC, 8'h01);
        wr(ADDR_DIV_RATIO, v);
        spi(1'b1, ADDR_DIV_RATIO, 8'h00, q);
        `CHK(q, v)
        gap(n);
        `CHK(n, exp_gap(1'b1, v[2:0]))
        spi(1'b1, ADDR_CLK_STATUS, 8'h00, q);
        `CHK(q[STAT_RF_BIT], 1'b1)
        wr(ADDR_CLK_SRC, 8'h00);
        #1 hi = 8'h03;
        lo = 8'h07;
        wr(ADDR_DCS_CTRL, 8'h00);
        wr(ADDR_DIV_RATIO, 8'h00);
        hi_time(n);
        `CHK(n, 3)
        `CHK({active, locked}, 2'b00)
        wr(ADDR_DIV_RATIO, 8'h01);
        `CHK(active, 1'b1)
        hi_time(n);
        `CHK(n, 3)
        m = 0;
        while (locked !== 1'b1 && m < 1000) begin
            @(posedge clk);
            #1 m++;
        end
        `CHK(m + 40 >= DCS_LOCK_CYC && m <= 500, 1'b1)
        hi_time(n);
        `CHK(n, 10)
        gap(n);
        `CHK(n, 20)
        runt_on = 1'b0;
        #1 hi = 8'h05;
        lo = 8'h05;
        wr(ADDR_DIV_RATIO, 8'h07);
        for (i = 0; i < 3; i++) begin
            wr(ADDR_SYNC_CTRL, sync_m[i]);
            sync_probe(n);
            `CHK(n <= 30, sync_e[i][1])
            sync_probe(n);
            `CHK(n <= 30, sync_e[i][0])
        end
        complete_run;
    end
endmodule : scd_clock_divider_tb
